// File: verilog/srt_timer.sv
// Refresh interval timer: counter, time constant, compare flag, refresh request.
// Assumes a classic Wishbone master on clk_i and a refresh sequencer on the same clock
// that pulses refresh_cycle_done_i once per refresh cycle carried out.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps

// Overview of operation
// - Each request asks for 1, 2, 4, 6 or 8 refresh cycles by count code.
// - Eight-bit counter advances once per tick of the selected clock.
// - Counter equal to constant clears the counter to zero.
// - Without a match the counter wraps from 255 to zero.
// - Constant is eight bits; a match sets the compare flag.
// - With refresh enabled, each match raises a refresh request.
// - The request is held until the refresh work is done.
// - A match while a request is pending replaces it, never queues two.
// - With the interrupt enable set, a match raises the interrupt.
// - The interrupt holds until software clears the compare flag or the interrupt enable.
// - Clearing the compare flag leaves a pending refresh request alone.
// - Bits 31..8 of counter and constant read zero; writes must carry key A55A in bits 31..16.
// - Clock select: 000 stops, others divide bus clock by 4 to 4096.
// - The flag clears on a zero write only after reading it as one.
module srt_timer
    import srt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Refresh sequencer
    output logic             refresh_req_o,
    output logic      [3:0]  refresh_cycles_o,
    input  wire logic        refresh_cycle_done_i,
    // Compare match interrupt
    output logic             irq_o
);

    typedef struct packed {
        logic [7:0]  count;
        logic [7:0]  constant;
        logic        compare_match_flag;
        logic        cmf_armed;
        logic        compare_match_irq_enable;
        srt_sel_t    cks;
        srt_sel_t    rrc;
        logic        refresh_enable_en;
        logic        pend;
        srt_cycles_t remain;
        logic        ack;
        logic [31:0] rdata;
    } srt_state_s;

    srt_state_s state_q;
    srt_state_s state_d;

    srt_tick_if tick_bus ();

    srt_prescaler u_prescaler (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .tick_io (tick_bus.presc)
    );

    assign tick_bus.tick_sel = state_q.cks;

    // Cycles per request; reserved codes fall back to a single cycle
    function automatic srt_cycles_t rrc_cycles(input srt_sel_t code);
        case (code)
            3'h0:    rrc_cycles = 4'h1;
            3'h1:    rrc_cycles = 4'h2;
            3'h2:    rrc_cycles = 4'h4;
            3'h3:    rrc_cycles = 4'h6;
            3'h4:    rrc_cycles = 4'h8;
            default: rrc_cycles = 4'h1;
        endcase
    endfunction : rrc_cycles

    function automatic logic [31:0] read_mux(input srt_state_s s, input logic [7:0] adr);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (adr)
            SRT_OFS_CTRL_STATUS: begin
                v[SRT_CMF_BIT]               = s.compare_match_flag;
                v[SRT_COMPARE_MATCH_IRQ_ENABLE_BIT]              = s.compare_match_irq_enable;
                v[SRT_CKS_LSB+:3]            = s.cks;
                v[SRT_RRC_LSB+:3]            = s.rrc;
            end
            SRT_OFS_COUNT:       v[7:0] = s.count;
            SRT_OFS_CONSTANT:    v[7:0] = s.constant;
            SRT_OFS_SDRAM_CTRL:  v[SRT_REFRESH_ENABLE_EN_BIT] = s.refresh_enable_en;
            SRT_OFS_REFRESH_STS: begin
                v[SRT_PEND_BIT]       = s.pend;
                v[SRT_REMAIN_LSB+:4]  = s.remain;
            end
            default:             v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_mux

    logic req;
    logic wr;
    logic rd_take;
    logic key_ok;
    logic match;

    always_comb begin
        state_d = state_q;
        req     = wb_cyc_i && wb_stb_i;
        // Write takes effect at the edge where ack is seen high
        wr      = req && state_q.ack && wb_we_i;
        rd_take = req && state_q.ack && !wb_we_i;
        key_ok  = (wb_sel_i[3:2] == 2'b11) && (wb_dat_i[31:16] == SRT_WRITE_KEY);
        match   = tick_bus.tick && (state_q.count == state_q.constant);

        // Bus: one wait state, ack drops the cycle after it was given
        state_d.ack = req && !state_q.ack;
        if (req && !state_q.ack) begin
            state_d.rdata = read_mux(state_q, wb_adr_i);
        end

        // Counter
        if (tick_bus.tick) begin
            if (match) begin
                state_d.count = 8'h00;
            end else begin
                state_d.count = state_q.count + 8'h01;
            end
        end

        // Reading the flag as one arms the clear
        if (rd_take && (wb_adr_i == SRT_OFS_CTRL_STATUS) && state_q.compare_match_flag) begin
            state_d.cmf_armed = 1'b1;
        end

        if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                SRT_OFS_COUNT: begin
                    if (key_ok) begin
                        state_d.count = wb_dat_i[7:0];
                    end
                end
                SRT_OFS_CONSTANT: begin
                    if (key_ok) begin
                        state_d.constant = wb_dat_i[7:0];
                    end
                end
                SRT_OFS_CTRL_STATUS: begin
                    if (key_ok) begin
                        state_d.compare_match_irq_enable = wb_dat_i[SRT_COMPARE_MATCH_IRQ_ENABLE_BIT];
                        state_d.cks  = wb_dat_i[SRT_CKS_LSB+:3];
                        state_d.rrc  = wb_dat_i[SRT_RRC_LSB+:3];
                        if (!wb_dat_i[SRT_CMF_BIT] && state_q.cmf_armed) begin
                            state_d.compare_match_flag = 1'b0;
                        end
                        state_d.cmf_armed = 1'b0;
                    end
                end
                SRT_OFS_SDRAM_CTRL: begin
                    state_d.refresh_enable_en = wb_dat_i[SRT_REFRESH_ENABLE_EN_BIT];
                end
                default: begin
                    state_d.refresh_enable_en = state_q.refresh_enable_en;
                end
            endcase
        end

        // Set wins over a clear in the same cycle; refresh path untouched by it
        if (match) begin
            state_d.compare_match_flag = 1'b1;
        end

        // Refresh request bookkeeping
        if (state_q.pend && refresh_cycle_done_i) begin
            if (state_q.remain <= 4'h1) begin
                state_d.pend   = 1'b0;
                state_d.remain = 4'h0;
            end else begin
                state_d.remain = state_q.remain - 4'h1;
            end
        end
        if (match && state_q.refresh_enable_en) begin
            // Older request is dropped and replaced
            state_d.pend   = 1'b1;
            state_d.remain = rrc_cycles(state_q.rrc);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q          <= '0;
            state_q.count    <= SRT_COUNT_RST;
            state_q.constant <= SRT_CONSTANT_RST;
            state_q.cks      <= SRT_CKS_RST;
            state_q.rrc      <= SRT_RRC_RST;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    assign wb_ack_o         = state_q.ack;
    assign wb_dat_o         = state_q.rdata;
    assign refresh_req_o    = state_q.pend;
    assign refresh_cycles_o = state_q.remain;
    assign irq_o            = state_q.compare_match_flag && state_q.compare_match_irq_enable;

endmodule : srt_timer

// File: verilog/srt_pkg.sv
// Constants, field layout and state types of the refresh interval timer.
// Assumes a 32-bit classic Wishbone register bus and a same-clock refresh sequencer.
package srt_pkg;

    // Register byte offsets
    localparam logic [7:0] SRT_OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] SRT_OFS_COUNT       = 8'h04;
    localparam logic [7:0] SRT_OFS_CONSTANT    = 8'h08;
    localparam logic [7:0] SRT_OFS_SDRAM_CTRL  = 8'h0C;
    localparam logic [7:0] SRT_OFS_REFRESH_STS = 8'h10;

    // Write key in the upper halfword
    localparam logic [15:0] SRT_WRITE_KEY = 16'hA55A;

    // Field positions of the control/status, SDRAM control and refresh status registers
    localparam int SRT_CMF_BIT      = 7;
    localparam int SRT_COMPARE_MATCH_IRQ_ENABLE_BIT     = 6;
    localparam int SRT_CKS_LSB      = 3;
    localparam int SRT_RRC_LSB      = 0;
    localparam int SRT_REFRESH_ENABLE_EN_BIT  = 0;
    localparam int SRT_PEND_BIT     = 4;
    localparam int SRT_REMAIN_LSB   = 0;

    // Reset values
    localparam logic [7:0] SRT_COUNT_RST    = 8'h00;
    localparam logic [7:0] SRT_CONSTANT_RST = 8'h00;
    localparam logic [2:0] SRT_CKS_RST      = 3'h0;
    localparam logic [2:0] SRT_RRC_RST      = 3'h0;

    // Prescaler width covers the largest divider, 4096
    localparam int SRT_PRESC_W = 12;

    typedef logic [2:0] srt_sel_t;
    typedef logic [3:0] srt_cycles_t;

endpackage : srt_pkg

// File: verilog/srt_tick_if.sv
// Tick request from the timer to the bus-clock prescaler.
// Assumes both ends share clk_i.
`timescale 1ns/10ps
interface srt_tick_if;
    import srt_pkg::*;
    srt_sel_t tick_sel;
    logic     tick;

    modport timer (output tick_sel, input tick);
    modport presc (input tick_sel, output tick);
endinterface : srt_tick_if

// File: verilog/srt_prescaler.sv
// Bus clock prescaler giving one-cycle ticks at /4 .. /4096.
// Assumes clk_i is the bus clock; select 000 gives no ticks.
`timescale 1ns/10ps
module srt_prescaler
    import srt_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    srt_tick_if.presc tick_io
);

    typedef struct packed {
        logic [SRT_PRESC_W-1:0] presc;
    } srt_presc_s;

    srt_presc_s state_q;
    srt_presc_s state_d;

    // Mask of low prescaler bits that must all be one for a tick
    function automatic logic [SRT_PRESC_W-1:0] div_mask(input srt_sel_t sel);
        case (sel)
            3'h1:    div_mask = 12'h0003;
            3'h2:    div_mask = 12'h000F;
            3'h3:    div_mask = 12'h003F;
            3'h4:    div_mask = 12'h00FF;
            3'h5:    div_mask = 12'h03FF;
            3'h6:    div_mask = 12'h07FF;
            3'h7:    div_mask = 12'h0FFF;
            default: div_mask = 12'h0000;
        endcase
    endfunction : div_mask

    logic [SRT_PRESC_W-1:0] mask;

    always_comb begin
        mask          = div_mask(tick_io.tick_sel);
        state_d       = state_q;
        state_d.presc = state_q.presc + 12'h001;
        tick_io.tick  = ce_i && (tick_io.tick_sel != 3'h0)
                        && ((state_q.presc & mask) == mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

endmodule : srt_prescaler

// File: tb/srt_seq_model.sv
// Behavioural refresh sequencer facing the timer's refresh request.
// Assumes the same clk_i as the timer; the bench may stall it at will.
`timescale 1ns/10ps
module srt_seq_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic       stall_i,
    output logic            done_o,
    output logic      [7:0] served_o
);
    logic [7:0] n_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o   <= 1'b0;
            n_q      <= 8'h00;
            served_o <= 8'h00;
        end else begin
            // Every other cycle, so no pulse lands after the request is met
            done_o <= req_i && !stall_i && !done_o;
            n_q    <= done_o ? n_q + 8'h01 : n_q;
            if (!req_i && n_q != 8'h00 && !done_o) begin
                served_o <= n_q;
                n_q      <= 8'h00;
            end
        end
    end
endmodule : srt_seq_model

// File: tb/srt_timer_sva.sv
// Port-level checks of the refresh interval timer.
// Assumes a single clk_i domain with synchronous rst_i.
`timescale 1ns/10ps
module srt_timer_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        refresh_req_o,
    input wire logic [3:0]  refresh_cycles_o,
    input wire logic        refresh_cycle_done_i,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_rsv; wb_ack_o && !wb_we_i && (wb_adr_i == 8'h04 || wb_adr_i == 8'h08)
        |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
    a_rsv: assert property (p_rsv) else $error("upper bits not zero");
    property p_hold; refresh_req_o && !refresh_cycle_done_i |=> refresh_req_o; endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_pair; refresh_req_o == (refresh_cycles_o != 4'h0); endproperty
    a_pair: assert property (p_pair) else $error("request and count disagree");
    property p_max; refresh_cycles_o <= 4'h8; endproperty
    a_max: assert property (p_max) else $error("cycle count too big");
    property p_dec; refresh_req_o && refresh_cycle_done_i |=> (refresh_cycles_o ==
        $past(refresh_cycles_o) - 4'h1) || (refresh_cycles_o inside {1, 2, 4, 6, 8});
    endproperty
    a_dec: assert property (p_dec) else $error("count not decremented");
    property p_irq; irq_o && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00)
        |=> irq_o; endproperty
    a_irq: assert property (p_irq) else $error("irq fell alone");
    property p_clr; $fell(irq_o) && !$past(refresh_cycle_done_i) |-> $stable(refresh_req_o);
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear moved request");
endmodule : srt_timer_sva
bind srt_timer srt_timer_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .refresh_req_o(refresh_req_o), .refresh_cycles_o(refresh_cycles_o),
    .refresh_cycle_done_i(refresh_cycle_done_i), .irq_o(irq_o));

// File: tb/srt_timer_test.sv
// Register-level bench of the refresh interval timer with a sequencer model.
// Assumes Wishbone answers within 50 cycles; ce_i and sel are held constant.
`timescale 1ns/10ps
module srt_timer_test;
    import srt_pkg::*;
    logic clk_i, rst_i, cyc, we, ack, req, done, irq, stall;
    logic [7:0] adr, served;
    logic [31:0] dat, rdat, q;
    logic [3:0] cyc_left;
    int mismatches = 0, comparisons = 0;
    srt_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .refresh_req_o(req), .refresh_cycles_o(cyc_left),
        .refresh_cycle_done_i(done), .irq_o(irq));
    srt_seq_model seq_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .stall_i(stall),
        .done_o(done), .served_o(served));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin mismatches++; conclude(); end
        q = rdat;
        cyc <= 1'b0; we <= 1'b0;
    endtask : bus
    task automatic waitv(input bit k, input logic v);
        int n;
        for (n = 0; n < 2000 && (k ? irq : req) !== v; n++) @(posedge clk_i);
        if (n >= 2000) begin mismatches++; conclude(); end
        @(negedge clk_i);
    endtask : waitv
    function automatic logic [31:0] ctl(input logic ie, input logic [2:0] s, input logic [2:0] r);
        return {SRT_WRITE_KEY, 8'h00, 1'b0, ie, s, r};
    endfunction : ctl
    int nexp [6] = '{1, 2, 4, 6, 8, 1};
    initial begin
        rst_i = 1'b1; cyc = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0000_0000; stall = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, 8'h14, 32'hFFFF_FFFF);
        for (int a = 0; a <= 8'h14; a += 4) begin bus(1'b0, a[7:0], 0); chk("reset", 0, q); end
        bus(1'b1, 8'h04, 32'h0000_0055); bus(1'b0, 8'h04, 0); chk("nokey", 0, q);
        bus(1'b1, 8'h08, 32'h5AA5_0011); bus(1'b0, 8'h08, 0); chk("badkey", 0, q);
        bus(1'b1, 8'h04, 32'hA55A_FF33); bus(1'b0, 8'h04, 0); chk("key", 32'h33, q);
        $display("test registers done");
        bus(1'b1, 8'h08, 32'hA55A_00FF);
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, 8'h00, ctl(0, s[2:0], 0)); bus(1'b1, 8'h04, {SRT_WRITE_KEY, 16'h0000});
            repeat (4 * (s == 0 ? 4 : s <= 4 ? 4 << (2 * s - 2) : 1024 << (s - 5))) @(posedge clk_i);
            bus(1'b0, 8'h04, 0);
            chk("ticks", 1, s == 0 ? q == 0 : q >= 3 && q <= 5);
        end
        // Constant below the start value, so the count wraps with no match on the way
        bus(1'b1, 8'h08, 32'hA55A_0014);
        bus(1'b1, 8'h04, 32'hA55A_00FE); bus(1'b1, 8'h00, ctl(0, 1, 0));
        repeat (16) @(posedge clk_i);
        bus(1'b0, 8'h04, 0); chk("wrap", 1, q >= 1 && q <= 3);
        $display("test counting done");
        bus(1'b1, 8'h08, 32'hA55A_0014); bus(1'b1, 8'h0C, 32'h0000_0001);
        for (int c = 0; c < 6; c++) begin
            stall <= 1'b1;
            bus(1'b1, 8'h00, ctl(0, 1, c[2:0])); waitv(0, 1'b1);
            bus(1'b0, 8'h10, 0); chk("pending", 32'h10 | nexp[c], q);
            bus(1'b0, 8'h04, 0); chk("count_le", 1, q[7:0] <= 8'h14);
            repeat (100) @(posedge clk_i);
            bus(1'b0, 8'h10, 0); chk("no_accum", 32'h10 | nexp[c], q);
            stall <= 1'b0;
            waitv(0, 1'b0); repeat (2) @(posedge clk_i);
            chk("served", nexp[c], {24'h00_0000, served});
        end
        $display("test refresh done");
        chk("irq_masked", 0, irq);
        bus(1'b1, 8'h00, ctl(1, 1, 0)); @(negedge clk_i); chk("irq_on", 1, irq);
        stall <= 1'b1;
        waitv(0, 1'b1);
        chk("irq_held", 1, irq);
        bus(1'b0, 8'h00, 0); chk("flag", 32'hC8, q);
        bus(1'b1, 8'h00, ctl(1, 1, 0)); @(negedge clk_i);
        chk("irq_clr", 0, irq);
        chk("req_kept", 1, req);
        stall <= 1'b0;
        $display("test flag done");
        conclude();
    end
endmodule : srt_timer_test
